// ### mss_pkg.sv
// mss_pkg: constants and types for the memory select and volume switch block.
// Assumes one 100 MHz system clock and registers reached over APB.
package mss_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_MS  = 10;
  localparam int unsigned FADE_MS      = 8;
  localparam int unsigned TONE_MS      = 100;
  localparam real         HOLD_SHORT_S = 1.5;
  localparam real         HOLD_MID_S   = 3.5;
  localparam real         HOLD_LONG_S  = 5.5;
  localparam int unsigned MSS_DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned MSS_FADE_CYC     = FADE_MS * CYC_PER_MS;
  localparam int unsigned MSS_TONE_CYC     = TONE_MS * CYC_PER_MS;
  localparam int unsigned MSS_HOLD1_CYC = int'(HOLD_SHORT_S * CLK_HZ);
  localparam int unsigned MSS_HOLD2_CYC = int'(HOLD_MID_S * CLK_HZ);
  localparam int unsigned MSS_HOLD3_CYC = int'(HOLD_LONG_S * CLK_HZ);

  // ***************************************************************
  // Register map and fields
  // ***************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] LIMITS_OFS = 8'h04;
  localparam logic [7:0] VOLUME_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam int CF_STATIC = 0;
  localparam int CF_LASTD  = 1;
  localparam int CF_POL1   = 2;
  localparam int CF_POL2   = 3;
  localparam int CF_CNT    = 4;
  localparam int CF_VSRC   = 7;
  localparam int CF_LOG    = 9;
  localparam int CF_ROCK   = 10;
  localparam int CF_TONE   = 11;
  localparam int CF_HOLD   = 12;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0010;
  localparam logic [31:0] LIMITS_RST = 32'h0001_ff00;
  localparam logic [7:0]  VOLUME_RST = 8'h80;
  localparam logic [2:0]  MAX_MEMS   = 3'h6;
  localparam logic [2:0]  MEM_A      = 3'h0;
  localparam logic [2:0]  MEM_B      = 3'h1;

  // Volume source selection
  localparam logic [1:0] VSRC_SW     = 2'h0;
  localparam logic [1:0] VSRC_ANALOG = 2'h1;
  localparam logic [1:0] VSRC_DIGIT  = 2'h2;

  typedef enum logic [1:0] {FD_IDLE, FD_OUT, FD_TONE, FD_IN} mss_fade_e;

endpackage

// ### mss_debounce.sv
// mss_debounce: synchroniser and debouncer for one switch pin.
// Assumes an asynchronous pin; invert is a static setting on clk_sys.
`timescale 1ns/1ps
module mss_debounce
  import mss_pkg::*;
#(
  parameter int unsigned CYC = MSS_DEBOUNCE_CYC
)
(
  // Clock and reset
  input  logic clk_sys,
  input  logic rst_n,
  // Pin side
  input  logic pin,
  input  logic invert,
  // Clean outputs
  output logic closed,
  output logic press
);

  logic        sync1_reg;
  logic        sync2_reg;
  logic        level;
  logic [31:0] cnt_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  assign level = sync2_reg ^ invert;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 32'h0;
      closed  <= 1'b0;
      press   <= 1'b0;
    end
    else
    begin
      press <= 1'b0;
      if (level == closed)
        cnt_reg <= 32'h0;
      else if (cnt_reg == 32'(CYC - 1))
      begin
        cnt_reg <= 32'h0;
        closed  <= level;
        press   <= level;
      end
      else
        cnt_reg <= cnt_reg + 32'h1;
    end
  end

endmodule

// ### mss_fader.sv
// mss_fader: sequences a memory change through fade, tone and fade-in.
// Assumes target memory is a registered request on clk_sys.
`timescale 1ns/1ps
module mss_fader
  import mss_pkg::*;
#(
  parameter int unsigned FADE_CYC = MSS_FADE_CYC,
  parameter int unsigned TONE_CYC = MSS_TONE_CYC
)
(
  // Clock and reset
  input  logic       clk_sys,
  input  logic       rst_n,
  // Request
  input  logic [2:0] target,
  input  logic       tone_en,
  // Audio path control
  output logic [2:0] active,
  output logic       fade_out,
  output logic       fade_in,
  output logic       tone_on
);

  mss_fade_e   state_reg;
  mss_fade_e   state_next;
  logic [31:0] cnt_reg;
  logic        done;

  assign done = (state_reg == FD_TONE) ? (cnt_reg == 32'(TONE_CYC - 1))
                                       : (cnt_reg == 32'(FADE_CYC - 1));

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      FD_IDLE: if (target != active) state_next = FD_OUT;
      FD_OUT:  if (done) state_next = tone_en ? FD_TONE : FD_IN;
      FD_TONE: if (done) state_next = FD_IN;
      default: if (done) state_next = FD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= FD_IDLE;
      cnt_reg   <= 32'h0;
      active    <= MEM_A;
      fade_out  <= 1'b0;
      fade_in   <= 1'b0;
      tone_on   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? 32'h0 : cnt_reg + 32'h1;
      if (state_next == FD_IN && state_reg != FD_IN)
        active <= target;
      fade_out <= (state_next == FD_OUT) || (state_next == FD_TONE);
      fade_in  <= (state_next == FD_IN);
      tone_on  <= (state_next == FD_TONE);
    end
  end

endmodule

// ### mss_top.sv
// mss_top: memory select switches and external volume control.
// Assumes switch pins are asynchronous, pot_level comes from an ADC
// on clk_sys, and an APB master on clk_sys reaches the registers.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module mss_top
  import mss_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = MSS_DEBOUNCE_CYC,
  parameter int unsigned FADE_CYC     = MSS_FADE_CYC,
  parameter int unsigned TONE_CYC     = MSS_TONE_CYC,
  parameter int unsigned HOLD1_CYC    = MSS_HOLD1_CYC,
  parameter int unsigned HOLD2_CYC    = MSS_HOLD2_CYC,
  parameter int unsigned HOLD3_CYC    = MSS_HOLD3_CYC
)
(
  // Clock and reset
  input  logic        clk_sys,
  input  logic        rst_n,
  // APB slave
  input  logic [7:0]  paddr,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Switch pins and potentiometer
  input  logic        select_switch_one,
  input  logic        select_switch_two,
  input  logic        volume_up_pin,
  input  logic        volume_down_pin,
  input  logic [7:0]  pot_level,
  // Audio path control
  output logic [2:0]  active_memory,
  output logic [7:0]  volume_gain,
  output logic        audio_fade_out,
  output logic        audio_fade_in,
  output logic        indicator_tone
);

  // ***************************************************************
  // Functions
  // ***************************************************************
  // Next memory in a cycle of n memories
  function automatic logic [2:0] mss_next(input logic [2:0] cur,
                                          input logic [2:0] n);
    logic [2:0] inc;
    inc = cur + 3'h1;
    return (inc >= n) ? MEM_A : inc;
  endfunction

  // Gain step with saturation
  function automatic logic [7:0] mss_step(input logic [7:0] g,
                                          input logic [7:0] st,
                                          input logic       up,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [8:0] s;
    s = up ? ({1'b0, g} + {1'b0, st}) : ({1'b0, g} - {1'b0, st});
    if (up && (s > {1'b0, hi}))
      return hi;
    else if (!up && (s[8] || (s[7:0] < lo)))
      return lo;
    else
      return s[7:0];
  endfunction

  // ***************************************************************
  // Registers and settings
  // ***************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] limits_reg;
  logic [7:0]  vol_sw_reg;
  logic        static_mode;
  logic        last_ded;
  logic [2:0]  mem_raw;
  logic [2:0]  mem_cnt;
  logic [1:0]  vol_src;
  logic        taper_log;
  logic        rocker_mem;
  logic        tone_en;
  logic [1:0]  hold_sel;
  logic [7:0]  gain_min;
  logic [7:0]  gain_max;
  logic [7:0]  gain_stp;

  assign static_mode = ctrl_reg[CF_STATIC];
  assign last_ded    = ctrl_reg[CF_LASTD];
  assign mem_raw     = ctrl_reg[CF_CNT +: 3];
  assign vol_src     = ctrl_reg[CF_VSRC +: 2];
  assign taper_log   = ctrl_reg[CF_LOG];
  assign rocker_mem  = ctrl_reg[CF_ROCK];
  assign tone_en     = ctrl_reg[CF_TONE];
  assign hold_sel    = ctrl_reg[CF_HOLD +: 2];
  assign gain_min    = limits_reg[7:0];
  assign gain_max    = limits_reg[15:8];
  assign gain_stp    = limits_reg[23:16];

  // Memory A always counts, never more than six
  assign mem_cnt = (mem_raw == 3'h0) ? 3'h1 :
                   (mem_raw > MAX_MEMS) ? MAX_MEMS : mem_raw;

  // ***************************************************************
  // Switch inputs
  // ***************************************************************
  logic [3:0] pins;
  logic [3:0] inv;
  logic [3:0] closed;
  logic [3:0] press;

  assign pins = {volume_down_pin, volume_up_pin,
                 select_switch_two, select_switch_one};
  assign inv  = {2'b00, ctrl_reg[CF_POL2], ctrl_reg[CF_POL1]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_db
      mss_debounce #(.CYC(DEBOUNCE_CYC)) u_db
      (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin     (pins[gi]),
        .invert  (inv[gi]),
        .closed  (closed[gi]),
        .press   (press[gi])
      );
    end
  endgenerate

  // ***************************************************************
  // Hold before leaving the last memory
  // ***************************************************************
  logic [31:0] hold_reg;
  logic        sw2_prev_reg;
  logic        sw2_eff;
  logic [31:0] hold_load;

  assign hold_load = (hold_sel == 2'h1) ? 32'(HOLD1_CYC) :
                     (hold_sel == 2'h2) ? 32'(HOLD2_CYC) :
                                          32'(HOLD3_CYC);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_reg     <= 32'h0;
      sw2_prev_reg <= 1'b0;
    end
    else
    begin
      sw2_prev_reg <= closed[1];
      if (closed[1] || !last_ded)
        hold_reg <= 32'h0;
      else if (sw2_prev_reg && hold_sel != 2'h0)
        hold_reg <= hold_load;
      else if (hold_reg != 32'h0)
        hold_reg <= hold_reg - 32'h1;
    end
  end

  // Previous-cycle term bridges the edge before the hold count loads
  assign sw2_eff = closed[1] || (hold_reg != 32'h0) ||
                   (sw2_prev_reg && hold_sel != 2'h0);

  // ***************************************************************
  // Memory selection
  // ***************************************************************
  logic [2:0] sel_reg;
  logic [2:0] saved_reg;
  logic       in_last_reg;
  logic [2:0] last_mem;
  logic [2:0] cyc_len;
  logic [2:0] static_sel;
  logic       adv;

  assign last_mem = mem_cnt - 3'h1;
  assign cyc_len  = (last_ded && mem_cnt > 3'h1) ? last_mem
                                                 : mem_cnt;
  assign adv = press[0] ||
               (rocker_mem && vol_src == VSRC_DIGIT && press[3]);

  always_comb
  begin
    if (last_ded)
    begin
      if (sw2_eff)
        static_sel = last_mem;
      else if (closed[0] && mem_cnt > MEM_B)
        static_sel = MEM_B;
      else
        static_sel = MEM_A;
    end
    else
    begin
      static_sel = {1'b0, closed[1], closed[0]};
      if (static_sel >= mem_cnt)
        static_sel = MEM_A;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_reg     <= MEM_A;
      saved_reg   <= MEM_A;
      in_last_reg <= 1'b0;
    end
    else if (static_mode)
    begin
      sel_reg     <= static_sel;
      in_last_reg <= 1'b0;
    end
    else if (last_ded && sw2_eff)
    begin
      if (!in_last_reg)
      begin
        saved_reg   <= sel_reg;
        in_last_reg <= 1'b1;
      end
      sel_reg <= last_mem;
    end
    else if (in_last_reg)
    begin
      sel_reg     <= saved_reg;
      in_last_reg <= 1'b0;
    end
    else if (sel_reg >= cyc_len)
      sel_reg <= MEM_A;
    else if (adv)
      sel_reg <= mss_next(sel_reg, cyc_len);
  end

  mss_fader #(.FADE_CYC(FADE_CYC), .TONE_CYC(TONE_CYC)) u_fader
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .target   (sel_reg),
    .tone_en  (tone_en),
    .active   (active_memory),
    .fade_out (audio_fade_out),
    .fade_in  (audio_fade_in),
    .tone_on  (indicator_tone)
  );

  // ***************************************************************
  // Volume
  // ***************************************************************
  logic [7:0]  span;
  logic [15:0] pot_sq;
  logic [7:0]  pot_t;
  logic [15:0] scaled;
  logic        vol_wr;

  assign span   = (gain_max > gain_min) ? gain_max - gain_min : 8'h0;
  assign pot_sq = pot_level * pot_level;
  assign pot_t  = taper_log ? pot_sq[15:8] : pot_level;
  assign scaled = pot_t * span;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      volume_gain <= VOLUME_RST;
    else if (vol_src == VSRC_ANALOG)
      volume_gain <= gain_min + scaled[15:8];
    else if (vol_src != VSRC_DIGIT)
      volume_gain <= vol_sw_reg;
    else if (vol_wr)
      volume_gain <= pwdata[7:0];
    else if (press[2])
      volume_gain <= mss_step(volume_gain, gain_stp, 1'b1,
                              gain_min, gain_max);
    else if (press[3] && !rocker_mem)
      volume_gain <= mss_step(volume_gain, gain_stp, 1'b0,
                              gain_min, gain_max);
  end

  // ***************************************************************
  // APB slave
  // ***************************************************************
  logic        acc;
  logic        setup;
  logic [31:0] rd;
  logic        hit;

  assign setup  = psel && !penable;
  assign acc    = psel && penable && pready;
  assign vol_wr = acc && pwrite && (paddr == VOLUME_OFS);

  always_comb
  begin
    rd  = 32'h0;
    hit = 1'b1;
    if (paddr == CTRL_OFS)
      rd = ctrl_reg;
    else if (paddr == LIMITS_OFS)
      rd = limits_reg;
    else if (paddr == VOLUME_OFS)
      rd = {24'h0, vol_sw_reg};
    else if (paddr == STATUS_OFS)
      rd = {8'h0, volume_gain, 4'h0, (hold_reg != 32'h0), closed[1],
            closed[0], audio_fade_out | audio_fade_in, 1'b0, sel_reg,
            1'b0, active_memory};
    else
      hit = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite) ? rd : 32'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg   <= CTRL_RST;
      limits_reg <= LIMITS_RST;
      vol_sw_reg <= VOLUME_RST;
    end
    else if (acc && pwrite)
    begin
      if (paddr == CTRL_OFS)
        ctrl_reg <= {18'h0, pwdata[13:0]};
      else if (paddr == LIMITS_OFS)
        limits_reg <= {8'h0, pwdata[23:0]};
      else if (paddr == VOLUME_OFS)
        vol_sw_reg <= pwdata[7:0];
    end
  end

endmodule

// ### mss_switch_model.sv
// Switch and rocker model facing the memory select block.
// Assumes the bench drives closure flags on clk_sys edges.
`timescale 1ns/1ps
module mss_switch_model
(
  // Closures: 0 one, 1 two, 2 up, 3 down
  input  logic [3:0] close_flags,
  input  logic       pol_one,
  input  logic       pol_two,
  // Pins
  output logic       pin_one,
  output logic       pin_two,
  output logic       pin_up,
  output logic       pin_down
);
  // ***************************************************************
  // Pin levels
  // ***************************************************************
  assign pin_one  = close_flags[0] ^ pol_one;
  assign pin_two  = close_flags[1] ^ pol_two;
  assign pin_up   = close_flags[2];
  assign pin_down = close_flags[3];
endmodule

// ### mss_top_assertions.sv
// Checker on the ports of mss_top.
// Assumes shortened fade counts handed on by the bind.
`timescale 1ns/1ps
module mss_checker
  import mss_pkg::*;
#(
  parameter int unsigned FADE_CYC = MSS_FADE_CYC
)
(
  input logic        clk_sys,
  input logic        rst_n,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [2:0]  active_memory,
  input logic [7:0]  volume_gain,
  input logic        audio_fade_out,
  input logic        audio_fade_in,
  input logic        indicator_tone
);
  // ***************************************************************
  // Helpers and properties
  // ***************************************************************
  int unsigned fin_cnt;
  logic        mapped;
  assign mapped = paddr inside {CTRL_OFS, LIMITS_OFS, VOLUME_OFS, STATUS_OFS};
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      fin_cnt <= 0;
    else
      fin_cnt <= audio_fade_in ? fin_cnt + 1 : 0;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property
    (psel && !penable |=> pslverr == !$past(mapped))
    else $error("pslverr wrong for address");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  chk_mem_valid: assert property (active_memory < MAX_MEMS)
    else $error("active memory out of range");
  chk_fade_apart: assert property (!(audio_fade_out && audio_fade_in))
    else $error("fade out and in together");
  chk_tone_fade: assert property (indicator_tone |-> audio_fade_out)
    else $error("tone outside muted span");
  chk_mem_fadein: assert property
    ($changed(active_memory) |-> $rose(audio_fade_in) && $past(audio_fade_out))
    else $error("memory switched outside fade");
  chk_fadein_len: assert property (audio_fade_in |-> fin_cnt < FADE_CYC)
    else $error("fade in too long");
  chk_fadein_full: assert property
    ($fell(audio_fade_in) |-> fin_cnt == FADE_CYC)
    else $error("fade in too short");
  cover property ($rose(audio_fade_in));
  cover property ($rose(indicator_tone));
  cover property (pready && pslverr);
endmodule

bind mss_top mss_checker #(.FADE_CYC(FADE_CYC)) u_chk
(
  .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .active_memory(active_memory),
  .volume_gain(volume_gain), .audio_fade_out(audio_fade_out),
  .audio_fade_in(audio_fade_in), .indicator_tone(indicator_tone)
);

// ### memory_select_and_volume_switches_tb_top.sv
// Self-checking bench for mss_top with a switch model.
// Assumes shortened counts: debounce 4, fade 3, tone 5, hold 20.
`timescale 1ns/1ps
module memory_select_and_volume_switches_tb_top;
  import mss_pkg::*;
  typedef struct {logic [31:0] ctrl; logic [1:0] sw;
                  logic [2:0] mem;} mss_row_s;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, pot_level, volume_gain;
  logic [31:0] pwdata, prdata, ctrl_q, rd;
  logic        s1, s2, vu, vd, fo, fi, tone, er;
  logic [2:0]  active_memory;
  logic [3:0]  sw_close;
  int          n_errors, comparisons, n;
  mss_row_s rows [13] = '{
    '{32'h841, 2'b01, 3'h1}, '{32'h841, 2'b11, 3'h3},
    '{32'h841, 2'b10, 3'h2}, '{32'h841, 2'b00, 3'h0},
    '{32'h821, 2'b10, 3'h0}, '{32'h821, 2'b01, 3'h1},
    '{32'h821, 2'b11, 3'h0}, '{32'h84f, 2'b01, 3'h1},
    '{32'h84f, 2'b11, 3'h3}, '{32'h84f, 2'b10, 3'h3},
    '{32'h84f, 2'b00, 3'h0}, '{32'h81f, 2'b01, 3'h0},
    '{32'h81f, 2'b00, 3'h0}};

  // ***************************************************************
  // Instances, clock and tasks
  // ***************************************************************
  mss_top #(.DEBOUNCE_CYC(4), .FADE_CYC(3), .TONE_CYC(5), .HOLD1_CYC(20),
            .HOLD2_CYC(40)) dut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .select_switch_one(s1),
    .select_switch_two(s2), .volume_up_pin(vu), .volume_down_pin(vd),
    .pot_level(pot_level), .active_memory(active_memory),
    .volume_gain(volume_gain), .audio_fade_out(fo), .audio_fade_in(fi),
    .indicator_tone(tone)
  );
  mss_switch_model sw
  (
    .close_flags(sw_close), .pol_one(ctrl_q[CF_POL1]),
    .pol_two(ctrl_q[CF_POL2]), .pin_one(s1), .pin_two(s2), .pin_up(vu),
    .pin_down(vd)
  );
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic cfg(input logic [31:0] v);
    apb(1, CTRL_OFS, v);
    ctrl_q <= v;
  endtask
  // Waits until the fader has been quiet for 15 cycles
  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 300 && q < 15; i++)
    begin
      @(posedge clk_sys);
      q = (fo || fi) ? 0 : q + 1;
    end
  endtask
  task automatic press(input int k);
    sw_close[k] <= 1;
    repeat (10) @(posedge clk_sys);
    sw_close[k] <= 0;
    settle();
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    pot_level = 8'h80; sw_close = 4'h0; ctrl_q = CTRL_RST; rst_n = 0;
    n_errors = 0; comparisons = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    chk("mem_rst", active_memory, MEM_A);
    chk("gain_rst", volume_gain, 32'h80);
    apb(0, CTRL_OFS, 32'h0);
    chk("ctrl_rst", rd, CTRL_RST);
    apb(0, LIMITS_OFS, 32'h0);
    chk("limits_rst", rd, LIMITS_RST);
    apb(0, 8'h10, 32'h0);
    chk("unmapped_err", er, 1'b1);
    foreach (rows[i])
    begin
      cfg(rows[i].ctrl);
      sw_close[1:0] <= rows[i].sw;
      settle();
      chk("row_mem", active_memory, rows[i].mem);
    end
    cfg(32'h84f);
    sw_close[1] <= 1;
    settle();
    sw_close[0] <= 1;
    n = 0;
    repeat (30)
    begin
      @(posedge clk_sys);
      if (fo) n++;
    end
    chk("sw1_ignored", n, 0);
    sw_close[1:0] <= 2'b00;
    settle();
    cfg(32'h830);
    for (int i = 0; i < 4; i++)
    begin
      press(0);
      chk("mode1_mem", active_memory, (i + 1) % 3);
    end
    cfg(32'h1842);
    for (int i = 0; i < 4; i++)
    begin
      press(0);
      chk("mode2_mem", active_memory, (i + 2) % 3);
    end
    sw_close[1] <= 1;
    settle();
    chk("jump_last", active_memory, 3'h3);
    press(0);
    chk("press_ignored", active_memory, 3'h3);
    sw_close[1] <= 0;
    repeat (14) @(posedge clk_sys);
    chk("hold_last", active_memory, 3'h3);
    chk("hold_quiet", fo, 1'b0);
    repeat (20) @(posedge clk_sys);
    settle();
    chk("restored", active_memory, 3'h2);
    cfg(32'h540);
    press(3);
    chk("rocker_mem", active_memory, 3'h3);
    apb(1, LIMITS_OFS, 32'h0020_9010);
    cfg(32'h110);
    apb(1, VOLUME_OFS, 32'h80);
    press(2);
    chk("vol_up", volume_gain, 32'h90);
    for (int i = 0; i < 5; i++)
    begin
      press(3);
      chk("vol_down", volume_gain, (i < 4) ? 32'h70 - 32'h20 * i : 32'h10);
    end
    cfg(32'h090);
    repeat (5) @(posedge clk_sys);
    chk("pot_linear", volume_gain, 32'h50);
    press(2);
    chk("digital_off", volume_gain, 32'h50);
    cfg(32'h290);
    repeat (5) @(posedge clk_sys);
    chk("pot_log", volume_gain, 32'h30);
    cfg(32'h010);
    apb(1, VOLUME_OFS, 32'h44);
    repeat (2) @(posedge clk_sys);
    chk("gain_sw", volume_gain, 32'h44);
    rst_n <= 0;
    ctrl_q <= CTRL_RST;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    chk("gain_rerst", volume_gain, 32'h80);
    chk("mem_rerst", active_memory, MEM_A);
    apb(0, CTRL_OFS, 32'h0);
    chk("ctrl_rerst", rd, CTRL_RST);
    conclude();
  end
endmodule
